// >>> rtl/osd_dm_pkg.sv
// Constants and types for the display memory access block
package osd_dm_pkg;

	// Register write addresses; a read uses the same code with bit 7 set
	localparam logic [7:0] ADDR_HIGH_WR = 8'h05;
	localparam logic [7:0] ADDR_LOW_WR = 8'h06;
	localparam logic [7:0] DATA_IN_WR = 8'h07;
	localparam int READ_FLAG_BIT = 7;

	// Field positions in the address-high register
	localparam int AH_POS8_BIT = 0;
	localparam int AH_BYTE_SEL_BIT = 1;

	// Attribute byte field positions
	localparam int ATTR_LBC_BIT = 7;
	localparam int ATTR_BLK_BIT = 6;
	localparam int ATTR_INV_BIT = 5;

	// Reset values
	localparam logic [7:0] ADDR_HIGH_RST = 8'h00;
	localparam logic [7:0] ADDR_LOW_RST = 8'h00;
	localparam logic [7:0] DATA_IN_RST = 8'h00;

	// Escape byte that ends auto-increment
	localparam logic [7:0] ESCAPE_BYTE = 8'hFF;

	// Memory geometry
	localparam int POS_WIDTH = 9;
	localparam int ATTR_WIDTH = 3;

	// Timing: clock period and clear duration
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLEAR_TIME_NS = 20000;
	localparam int CLEAR_CYCLES = CLEAR_TIME_NS / CLK_PERIOD_NS;

	// Serial frame states
	typedef enum logic [1:0] {
		SER_CMD,
		SER_WR_DATA,
		SER_RD_DATA
	} ser_state_type;

	// Pixel source selection on the overlay
	typedef enum logic [1:0] {
		PIX_VIDEO,
		PIX_GRAY,
		PIX_WHITE,
		PIX_BLACK
	} pix_sel_type;

endpackage

// >>> rtl/osd_display_memory_access.sv
// Display memory access: serial register port, character map and pixel pick

// Notes on behaviour
// - Background pixel: video or gray per sync, mode and attribute background bit
// - Address-high write 0x05, read 0x85
// - 8-bit mode: byte-select picks index or attribute
// - Position is addr-high bit 0 plus addr-low
// - Address-low write 0x06, read 0x86, resets zero
// - Data-in 0x07/0x87, resets zero, stored at position
// - Attribute: background bit7, blink bit6, reverse bit5
// - 16-bit mode: data byte always character index
// - Auto-increment: 0xFF escapes, not stored
// - Reverse video swaps white and black pixels
// - Auto-increment starts at current position, then advances
// - Clear fills zeros, self-clears after about 20 us
module osd_display_memory_access
	import osd_dm_pkg::*;
#(
	parameter int DEPTH = 512
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Serial register port
	input wire logic spi_cs_b,
	input wire logic spi_sclk,
	input wire logic spi_sdin,
	output logic spi_sdout,
	// Mode bits held elsewhere
	input wire logic eight_bit_mode,
	input wire logic auto_inc_en,
	input wire logic clear_start,
	input wire logic [ATTR_WIDTH-1:0] mode_attr,
	input wire logic ext_sync,
	input wire logic bg_mode,
	// Status
	output logic clear_busy,
	output logic auto_inc_active,
	// Display read side
	input wire logic [POS_WIDTH-1:0] disp_rd_pos,
	input wire logic pix_is_char,
	input wire logic pix_white,
	output logic [7:0] char_index,
	output logic [ATTR_WIDTH-1:0] char_attr,
	output pix_sel_type pix_sel
);

	localparam int CLR_LEN = (CLEAR_CYCLES > DEPTH) ? CLEAR_CYCLES : DEPTH;
	localparam int CW = $clog2(CLR_LEN + 1);

	// Character map storage
	logic [7:0] char_mem [DEPTH];
	logic [ATTR_WIDTH-1:0] attr_mem [DEPTH];

	// Registers
	logic [1:0] addr_high_r;
	logic [7:0] addr_low_r;
	logic [7:0] data_in_r;
	logic [POS_WIDTH-1:0] auto_pos_r;
	logic auto_active_r;
	logic auto_en_q_r;
	logic clear_busy_r;
	logic [CW-1:0] clr_cnt_r;

	// Serial engine state
	ser_state_type ser_state_r;
	logic sclk_q_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic [7:0] cmd_r;
	logic sdout_r;

	// Strobes
	logic rise;
	logic fall;
	logic byte_done;
	logic [7:0] rx_byte;
	logic data_wr;
	logic store;
	logic store_attr;
	logic [POS_WIDTH-1:0] store_pos;
	logic [POS_WIDTH-1:0] reg_pos;
	logic [7:0] rd_val;

	assign rise = !spi_cs_b && spi_sclk && !sclk_q_r;
	assign fall = !spi_cs_b && !spi_sclk && sclk_q_r;
	assign byte_done = rise && (bit_cnt_r == 3'd7);
	assign rx_byte = {rx_r[6:0], spi_sdin};
	assign reg_pos = {addr_high_r[AH_POS8_BIT], addr_low_r};

	// A data byte is accepted only when no clear is running
	assign data_wr = byte_done && (ser_state_r == SER_WR_DATA) &&
		(cmd_r == DATA_IN_WR) && !clear_busy_r;
	// Escape is swallowed while auto-increment runs
	assign store = data_wr &&
		!(auto_active_r && (rx_byte == ESCAPE_BYTE));
	assign store_attr = eight_bit_mode &&
		addr_high_r[AH_BYTE_SEL_BIT];
	assign store_pos = auto_active_r ? auto_pos_r : reg_pos;

	// Read-back value for a command byte
	always_comb begin
		rd_val = 8'h00;
		case (rx_byte & ~(8'h01 << READ_FLAG_BIT))
			ADDR_HIGH_WR: rd_val = {6'b00_0000, addr_high_r};
			ADDR_LOW_WR: rd_val = addr_low_r;
			DATA_IN_WR: rd_val = data_in_r;
			default: rd_val = 8'h00;
		endcase
	end

	// Serial clock history; port inputs are synchronous to ref_clk,
	// so one history flop is enough to find the sclk edges
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sclk_q_r <= 1'b0;
		end else begin
			sclk_q_r <= spi_sclk;
		end
	end

	// Bit shifting and framing; a frame may carry several commands
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ser_state_r <= SER_CMD;
			bit_cnt_r <= 3'd0;
			rx_r <= 8'h00;
			cmd_r <= 8'h00;
		end else if (spi_cs_b) begin
			ser_state_r <= SER_CMD;
			bit_cnt_r <= 3'd0;
		end else if (rise) begin
			rx_r <= rx_byte;
			bit_cnt_r <= bit_cnt_r + 3'd1;
			if (bit_cnt_r == 3'd7) begin
				case (ser_state_r)
					SER_CMD: begin
						cmd_r <= rx_byte;
						ser_state_r <= rx_byte[READ_FLAG_BIT] ?
							SER_RD_DATA : SER_WR_DATA;
					end
					SER_WR_DATA: begin
						// Auto-increment streams data without commands
						if (auto_active_r && cmd_r == DATA_IN_WR &&
							rx_byte != ESCAPE_BYTE) begin
							ser_state_r <= SER_WR_DATA;
						end else begin
							ser_state_r <= SER_CMD;
						end
					end
					SER_RD_DATA: ser_state_r <= SER_CMD;
					default: ser_state_r <= SER_CMD;
				endcase
			end
		end
	end

	// Read data changes on falling edges so the host samples on rising
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tx_r <= 8'h00;
			sdout_r <= 1'b0;
		end else if (byte_done && ser_state_r == SER_CMD &&
			rx_byte[READ_FLAG_BIT]) begin
			tx_r <= rd_val;
		end else if (fall && ser_state_r == SER_RD_DATA) begin
			sdout_r <= tx_r[7];
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	// Address registers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			addr_high_r <= ADDR_HIGH_RST[1:0];
			addr_low_r <= ADDR_LOW_RST;
		end else if (byte_done && ser_state_r == SER_WR_DATA &&
			!clear_busy_r) begin
			if (cmd_r == ADDR_HIGH_WR) begin
				addr_high_r <= rx_byte[1:0];
			end
			if (cmd_r == ADDR_LOW_WR) begin
				addr_low_r <= rx_byte;
			end
		end
	end

	// Data-in register keeps the last accepted byte, escape included
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			data_in_r <= DATA_IN_RST;
		end else if (data_wr) begin
			data_in_r <= rx_byte;
		end
	end

	// Auto-increment: latch start on enable edge, advance per stored byte
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			auto_en_q_r <= 1'b0;
			auto_active_r <= 1'b0;
			auto_pos_r <= '0;
		end else begin
			auto_en_q_r <= auto_inc_en;
			if (clear_busy_r || !auto_inc_en) begin
				auto_active_r <= 1'b0;
			end else if (data_wr && rx_byte == ESCAPE_BYTE &&
				auto_active_r) begin
				auto_active_r <= 1'b0;
			end else if (auto_inc_en && !auto_en_q_r) begin
				auto_active_r <= 1'b1;
				auto_pos_r <= reg_pos;
			end else if (store && auto_active_r) begin
				auto_pos_r <= auto_pos_r + 1'b1;
			end
		end
	end

	// Clear sequencer; the sweep bounds it, so it may slightly exceed 20 us
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			clear_busy_r <= 1'b0;
			clr_cnt_r <= '0;
		end else if (!clear_busy_r) begin
			if (clear_start) begin
				clear_busy_r <= 1'b1;
				clr_cnt_r <= '0;
			end
		end else if (clr_cnt_r == CW'(CLR_LEN - 1)) begin
			clear_busy_r <= 1'b0;
		end else begin
			clr_cnt_r <= clr_cnt_r + 1'b1;
		end
	end

	// Memory writes: clear sweep has priority over host data
	always_ff @(posedge ref_clk) begin
		if (clear_busy_r) begin
			if (clr_cnt_r < CW'(DEPTH)) begin
				char_mem[clr_cnt_r[POS_WIDTH-1:0]] <= 8'h00;
				attr_mem[clr_cnt_r[POS_WIDTH-1:0]] <= '0;
			end
		end else if (store) begin
			if (store_attr) begin
				attr_mem[store_pos] <= rx_byte[ATTR_LBC_BIT:ATTR_INV_BIT];
			end else begin
				char_mem[store_pos] <= rx_byte;
				if (!eight_bit_mode) begin
					attr_mem[store_pos] <= mode_attr;
				end
			end
		end
	end

	// Display read port; the map has no reset, so the host must clear
	// it once before the overlay is trusted
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			char_index <= 8'h00;
			char_attr <= '0;
		end else begin
			char_index <= char_mem[disp_rd_pos];
			char_attr <= attr_mem[disp_rd_pos];
		end
	end

	// Pixel pick uses the attribute already registered for this position
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pix_sel <= PIX_VIDEO;
		end else if (pix_is_char) begin
			if (pix_white ^ char_attr[ATTR_INV_BIT - ATTR_INV_BIT]) begin
				pix_sel <= PIX_WHITE;
			end else begin
				pix_sel <= PIX_BLACK;
			end
		end else if (ext_sync && !bg_mode &&
			!char_attr[ATTR_LBC_BIT - ATTR_INV_BIT]) begin
			pix_sel <= PIX_VIDEO;
		end else begin
			pix_sel <= PIX_GRAY;
		end
	end

	// Serial data and status outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			spi_sdout <= 1'b0;
			clear_busy <= 1'b0;
			auto_inc_active <= 1'b0;
		end else begin
			spi_sdout <= sdout_r;
			clear_busy <= clear_busy_r;
			auto_inc_active <= auto_active_r;
		end
	end

endmodule // osd_display_memory_access

// >>> sim/osd_dm_props.sv
// Port checker for the display memory access block
module osd_dm_props
	import osd_dm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Watched ports
	input wire logic clear_start,
	input wire logic clear_busy,
	input wire logic auto_inc_en,
	input wire logic auto_inc_active,
	input wire logic ext_sync,
	input wire logic bg_mode,
	input wire logic pix_is_char,
	input wire logic pix_white,
	input wire logic [ATTR_WIDTH-1:0] char_attr,
	input wire pix_sel_type pix_sel
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic [9:0] busy_r;
	logic up_r;
	always_ff @(posedge ref_clk)
		busy_r <= (rst_b && clear_busy) ? busy_r + 10'h001 : 10'h000;
	// Outputs stay at reset value one edge after release
	always_ff @(posedge ref_clk)
		up_r <= rst_b;
	clear_go_a: assert property (clear_start && !clear_busy
		|-> ##2 clear_busy) else $error("clear did not start");
	clear_len_a: assert property ($fell(clear_busy)
		|-> busy_r == 10'h200) else $error("clear length wrong");
	bg_gray_a: assert property (up_r && !pix_is_char
		&& (!ext_sync || bg_mode || char_attr[2])
		|=> pix_sel == PIX_GRAY) else $error("background not gray");
	bg_video_a: assert property (up_r && !pix_is_char && ext_sync
		&& !bg_mode && !char_attr[2] |=> pix_sel == PIX_VIDEO)
		else $error("background not video");
	inv_white_a: assert property (up_r && pix_is_char
		&& pix_white != char_attr[0] |=> pix_sel == PIX_WHITE)
		else $error("pixel not white");
	inv_black_a: assert property (up_r && pix_is_char
		&& pix_white == char_attr[0] |=> pix_sel == PIX_BLACK)
		else $error("pixel not black");
	auto_on_a: assert property ($rose(auto_inc_en) && !clear_busy
		|-> ##[1:2] auto_inc_active) else $error("auto not started");
	auto_off_a: assert property (!auto_inc_en [*2]
		|-> !auto_inc_active) else $error("auto still on");
	clear_c: cover property ($fell(clear_busy));
	auto_c: cover property ($fell(auto_inc_active));
	video_c: cover property (up_r && ext_sync && !pix_is_char
		##1 pix_sel == PIX_VIDEO);
endmodule // osd_dm_props

bind osd_display_memory_access osd_dm_props i_osd_dm_props (
	.ref_clk(ref_clk), .rst_b(rst_b), .clear_start(clear_start),
	.clear_busy(clear_busy), .auto_inc_en(auto_inc_en),
	.auto_inc_active(auto_inc_active), .ext_sync(ext_sync),
	.bg_mode(bg_mode), .pix_is_char(pix_is_char), .pix_white(pix_white),
	.char_attr(char_attr), .pix_sel(pix_sel)
);

// >>> sim/host_bfm.sv
// Host model driving the serial register port
module host_bfm (
	// Clock
	input wire logic ref_clk,
	// Serial port
	output logic cs_b,
	output logic sclk,
	output logic sdin,
	input wire logic sdout
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_b = 1'b1;
		sclk = 1'b0;
		sdin = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Serial clock rests low between frames; data line toggles when idle
	task automatic sel(input logic on);
		tick(4);
		cs_b = !on;
		sdin = !sdin;
	endtask
	// Four ref_clk per half period, above the oversampling minimum
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			sdin = tx[i];
			tick(4);
			rx[i] = sdout;
			sclk = 1'b1;
			tick(4);
		end
		sclk = 1'b0;
		sdin = !sdin;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] junk;
		sel(1'b1);
		xfer(a, junk);
		xfer(d, junk);
		sel(1'b0);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sel(1'b1);
		xfer(a | 8'h80, d);
		xfer(8'h00, d);
		sel(1'b0);
	endtask
endmodule // host_bfm

// >>> sim/tb_top.sv
// Self-checking bench for the display memory access block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import osd_dm_pkg::*;
	logic ref_clk = 1'b0, rst_b = 1'b0, cs_b, sclk, sdin, sdout;
	logic eight_bit_mode = 1'b0, auto_inc_en = 1'b0, clear_start = 1'b0;
	logic ext_sync = 1'b0, bg_mode = 1'b0, pix_is_char = 1'b0;
	logic pix_white = 1'b0, clear_busy, auto_inc_active;
	logic [ATTR_WIDTH-1:0] mode_attr = 3'h2, char_attr;
	logic [POS_WIDTH-1:0] disp_rd_pos = 9'h000;
	logic [7:0] char_index, rd_byte;
	pix_sel_type pix_sel;
	int error_cnt = 0, compares = 0;
	initial forever #20 ref_clk = !ref_clk;
	osd_display_memory_access i_osd_display_memory_access (
		.ref_clk(ref_clk), .rst_b(rst_b), .spi_cs_b(cs_b),
		.spi_sclk(sclk), .spi_sdin(sdin), .spi_sdout(sdout),
		.eight_bit_mode(eight_bit_mode), .auto_inc_en(auto_inc_en),
		.clear_start(clear_start), .mode_attr(mode_attr),
		.ext_sync(ext_sync), .bg_mode(bg_mode), .clear_busy(clear_busy),
		.auto_inc_active(auto_inc_active), .disp_rd_pos(disp_rd_pos),
		.pix_is_char(pix_is_char), .pix_white(pix_white),
		.char_index(char_index), .char_attr(char_attr), .pix_sel(pix_sel)
	);
	host_bfm i_host_bfm (.ref_clk(ref_clk), .cs_b(cs_b), .sclk(sclk),
		.sdin(sdin), .sdout(sdout));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		for (n = 0; clear_busy !== lvl && n < 600; n++)
			cyc(1);
		if (n == 600) begin
			error_cnt++;
			stop_test();
		end
	endtask
	task automatic look(input logic [8:0] p, input logic [7:0] idx,
		input logic [2:0] at);
		disp_rd_pos = p;
		cyc(2);
		check(char_index, idx);
		check({5'h00, char_attr}, {5'h00, at});
	endtask
	task automatic clr;
		clear_start = 1'b1;
		cyc(1);
		clear_start = 1'b0;
		wait_busy(1'b1);
	endtask
	task automatic s_clear;
		clr();
		wait_busy(1'b0);
		look(9'h000, 8'h00, 3'h0);
		look(9'h1FF, 8'h00, 3'h0);
	endtask
	task automatic s_regs;
		for (int a = 5; a < 8; a++) begin
			i_host_bfm.rd(8'(a), rd_byte);
			check(rd_byte, 8'h00);
		end
		i_host_bfm.wr(8'h05, 8'hFF);
		i_host_bfm.rd(8'h05, rd_byte);
		check(rd_byte, 8'h03);
	endtask
	task automatic s_store;
		i_host_bfm.wr(8'h06, 8'h34);
		i_host_bfm.wr(8'h07, 8'hFF);
		look(9'h134, 8'hFF, 3'h2);
		i_host_bfm.rd(8'h07, rd_byte);
		check(rd_byte, 8'hFF);
		eight_bit_mode = 1'b1;
		i_host_bfm.wr(8'h07, 8'hA0);
		look(9'h134, 8'hFF, 3'h5);
		i_host_bfm.wr(8'h05, 8'h01);
		i_host_bfm.wr(8'h07, 8'h22);
		look(9'h134, 8'h22, 3'h5);
	endtask
	task automatic s_auto;
		logic [7:0] seq [4] = '{8'h07, 8'h41, 8'h42, 8'hFF};
		i_host_bfm.wr(8'h05, 8'h00);
		i_host_bfm.wr(8'h06, 8'h10);
		auto_inc_en = 1'b1;
		i_host_bfm.sel(1'b1);
		foreach (seq[i])
			i_host_bfm.xfer(seq[i], rd_byte);
		i_host_bfm.sel(1'b0);
		check({7'h00, auto_inc_active}, 8'h00);
		auto_inc_en = 1'b0;
		look(9'h010, 8'h41, 3'h0);
		look(9'h011, 8'h42, 3'h0);
		look(9'h012, 8'h00, 3'h0);
	endtask
	task automatic s_pix;
		logic [2:0] at;
		pix_sel_type exp;
		for (int i = 0; i < 32; i++) begin
			disp_rd_pos = i[4] ? 9'h134 : 9'h000;
			{ext_sync, bg_mode, pix_is_char, pix_white} = i[3:0];
			// Attribute {background, blink, reverse} left by earlier scenarios
			at = i[4] ? 3'h5 : 3'h0;
			if (pix_is_char)
				exp = (pix_white ^ at[0]) ? PIX_WHITE : PIX_BLACK;
			else if (ext_sync && !bg_mode && !at[2])
				exp = PIX_VIDEO;
			else
				exp = PIX_GRAY;
			cyc(2);
			check(8'(pix_sel), 8'(exp));
		end
	endtask
	// Writes during the clear on purpose to see them dropped
	task automatic s_busy;
		clr();
		i_host_bfm.wr(8'h06, 8'h55);
		wait_busy(1'b0);
		i_host_bfm.rd(8'h06, rd_byte);
		check(rd_byte, 8'h10);
		look(9'h010, 8'h00, 3'h0);
	endtask
	initial begin
		cyc(2);
		rst_b = 1'b1;
		s_clear();
		s_regs();
		s_store();
		s_auto();
		s_pix();
		s_busy();
		stop_test();
	end
endmodule // tb_top
